// [rtl/embt_ext_mem_bus_timing.sv]
// External memory bus timing engine with its timing register
`timescale 1ns/1ps
module embt_ext_mem_bus_timing (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// Special function register port
	input  wire logic [7:0]        regAddr,
	input  wire logic              regWrite,
	input  wire logic [7:0]        regWdata,
	output logic [7:0]             regRdata,
	// Configuration from neighbouring registers
	input  wire logic [1:0]        busOperatingMode,
	input  wire logic [1:0]        latchWidthSelect,
	input  wire logic [7:0]        xramPageSelect,
	// Core access request and answer
	input  wire logic              reqValid,
	input  wire embt_pkg::embt_req_t req,
	output logic                   reqReady,
	output logic                   accDone,
	output logic [7:0]             readData,
	// External bus pins
	output logic                   aleOut,
	output logic                   rdStrobeN,
	output logic                   wrStrobeN,
	output logic [7:0]             addrHigh,
	output logic                   addrHighOe,
	output logic [7:0]             adOut,
	output logic                   adOe,
	input  wire logic [7:0]        adIn
);
	import embt_pkg::*;

	// ----------------------------------------
	// Timing register
	// ----------------------------------------
	logic [7:0]   timing_q;
	embt_timing_t timing;
	wire          timingSel = (regAddr == EMBT_TIMING_ADDR);

	assign timing = embt_timing_t'(timing_q);

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			timing_q <= EMBT_TIMING_RST;
		else if (regWrite && timingSel)
			timing_q <= regWdata;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			regRdata <= 8'h00;
		else
			regRdata <= timingSel ? timing_q : 8'h00;
	end

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	embt_state_t state_q, state_d;
	embt_req_t   acc_q;
	logic        load;
	logic [4:0]  length;
	logic        last;

	// Mode 00 keeps all moves on chip; the block then answers without bus activity
	wire         extMode  = (busOperatingMode != EMBT_MODE_INT_ONLY);
	wire         bankMode = (busOperatingMode == EMBT_MODE_SPLIT_B);
	wire [4:0]   aleLen   = {3'h0, latchWidthSelect} + 5'h01;
	wire [4:0]   setupLen = {3'h0, timing.setupCycles};
	wire [4:0]   holdLen  = {3'h0, timing.holdCycles};
	wire [4:0]   strobeLen = {1'b0, timing.strobeCycles} + 5'h01;
	wire         start    = reqValid && (state_q == EMBT_IDLE);

	// Address of the access: short moves take the page byte as the high half
	wire [15:0]  reqAddr  = req.shortAddr ? {xramPageSelect, req.addr[7:0]} : req.addr;
	wire         driveBank = !acc_q.shortAddr || bankMode;

	embt_phase_timer #(
		.WIDTH (5)
	) u_timer (
		.mclk   (mclk),
		.rstn   (rstn),
		.load   (load),
		.length (length),
		.last   (last)
	);

	always_comb
	begin
		state_d = state_q;
		load    = 1'b0;
		length  = aleLen;
		case (state_q)
			EMBT_IDLE:
			begin
				if (reqValid && extMode)
				begin
					state_d = EMBT_ALEHI;
					load    = 1'b1;
					length  = aleLen;
				end
			end
			EMBT_ALEHI:
			begin
				if (last)
				begin
					state_d = EMBT_ALELO;
					load    = 1'b1;
					length  = aleLen;
				end
			end
			EMBT_ALELO:
			begin
				if (last)
				begin
					load = 1'b1;
					if (setupLen == 5'h00)
					begin
						state_d = EMBT_STROBE;
						length  = strobeLen;
					end
					else
					begin
						state_d = EMBT_SETUP;
						length  = setupLen;
					end
				end
			end
			EMBT_SETUP:
			begin
				if (last)
				begin
					state_d = EMBT_STROBE;
					load    = 1'b1;
					length  = strobeLen;
				end
			end
			EMBT_STROBE:
			begin
				if (last)
				begin
					load = 1'b1;
					length = holdLen;
					state_d = (holdLen == 5'h00) ? EMBT_IDLE : EMBT_HOLD;
				end
			end
			EMBT_HOLD:
			begin
				if (last)
					state_d = EMBT_IDLE;
			end
			default:
				state_d = EMBT_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= EMBT_IDLE;
			acc_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (start)
			begin
				acc_q      <= req;
				acc_q.addr <= reqAddr;
			end
		end
	end

	// ----------------------------------------
	// Registered pin drivers
	// ----------------------------------------
	wire endStrobe = (state_q == EMBT_STROBE) && last;
	wire endAcc    = ((state_d == EMBT_IDLE) && (state_q != EMBT_IDLE)) || (start && !extMode);
	wire inAddr    = (state_d == EMBT_ALEHI) || (state_d == EMBT_ALELO);
	wire inData    = (state_d == EMBT_SETUP) || (state_d == EMBT_STROBE) || (state_d == EMBT_HOLD);
	wire [15:0] nAddr = (state_q == EMBT_IDLE) ? reqAddr : acc_q.addr;
	wire nWrite    = (state_q == EMBT_IDLE) ? req.write : acc_q.write;
	wire nBank     = (state_q == EMBT_IDLE) ? (!req.shortAddr || bankMode) : driveBank;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			aleOut     <= 1'b0;
			rdStrobeN  <= 1'b1;
			wrStrobeN  <= 1'b1;
			addrHigh   <= 8'h00;
			addrHighOe <= 1'b0;
			adOut      <= 8'h00;
			adOe       <= 1'b0;
			reqReady   <= 1'b0;
			accDone    <= 1'b0;
			readData   <= 8'h00;
		end
		else
		begin
			aleOut     <= (state_d == EMBT_ALEHI);
			rdStrobeN  <= !((state_d == EMBT_STROBE) && !nWrite);
			wrStrobeN  <= !((state_d == EMBT_STROBE) && nWrite);
			addrHigh   <= nAddr[15:8];
			addrHighOe <= (inAddr || inData) && nBank;
			adOut      <= inAddr ? nAddr[7:0] : (nWrite ? acc_q.wdata : 8'h00);
			adOe       <= inAddr || (inData && nWrite);
			reqReady   <= (state_d == EMBT_IDLE) && !start;
			accDone    <= endAcc;
			if (endStrobe && !acc_q.write)
				readData <= adIn;
			else if (start && !extMode)
				readData <= 8'h00;
		end
	end
endmodule

// [rtl/embt_phase_timer.sv]
// Phase cycle counter: counts a loaded length down to the last cycle
`timescale 1ns/1ps
module embt_phase_timer #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rstn,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] length,
	// Status
	output logic                  last
);
	import embt_pkg::*;

	// Refuse a counter too narrow for the 16-cycle strobe
	if (WIDTH < 5)
	begin
		$error("embt_phase_timer: WIDTH must reach the 16-cycle strobe");
	end

	logic [WIDTH-1:0] count_q;

	assign last = (count_q <= WIDTH'(1));

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			count_q <= '0;
		else if (load)
			count_q <= length;
		else if (count_q != '0)
			count_q <= count_q - WIDTH'(1);
	end
endmodule

// [rtl/embt_pkg.sv]
// Package: constants and types for the external memory bus timing block
package embt_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] EMBT_TIMING_ADDR = 8'haf;
	localparam logic [7:0] EMBT_TIMING_RST  = 8'hff;

	// Timing register field positions
	localparam int EMBT_SETUP_LSB  = 6;
	localparam int EMBT_STROBE_LSB = 2;
	localparam int EMBT_HOLD_LSB   = 0;

	// ----------------------------------------
	// Operating modes
	// ----------------------------------------
	localparam logic [1:0] EMBT_MODE_INT_ONLY = 2'h0;
	localparam logic [1:0] EMBT_MODE_SPLIT_NB = 2'h1;
	localparam logic [1:0] EMBT_MODE_SPLIT_B  = 2'h2;
	localparam logic [1:0] EMBT_MODE_EXT_ONLY = 2'h3;

	// ----------------------------------------
	// Access sequence states
	// ----------------------------------------
	typedef enum logic [5:0] {
		EMBT_IDLE   = 6'b000001,
		EMBT_ALEHI  = 6'b000010,
		EMBT_ALELO  = 6'b000100,
		EMBT_SETUP  = 6'b001000,
		EMBT_STROBE = 6'b010000,
		EMBT_HOLD   = 6'b100000
	} embt_state_t;

	// Core-side access request
	typedef struct packed {
		logic        write;
		logic        shortAddr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} embt_req_t;

	// Decoded timing fields
	typedef struct packed {
		logic [1:0] setupCycles;
		logic [3:0] strobeCycles;
		logic [1:0] holdCycles;
	} embt_timing_t;

endpackage

// [tb/embt_ext_mem_bus_timing_asserts.sv]
// Checker for the bus timing block
`timescale 1ns/1ps
module embt_ext_mem_bus_timing_chk (
	// Clock and reset
	input wire logic	mclk,
	input wire logic	rstn,
	// Registers
	input wire logic [7:0]	regAddr,
	input wire logic	regWrite,
	input wire logic [7:0]	regWdata,
	input wire logic [7:0]	regRdata,
	// Config
	input wire logic [1:0]	busOperatingMode,
	input wire logic [1:0]	latchWidthSelect,
	input wire logic [7:0]	xramPageSelect,
	// Core
	input wire logic	reqValid,
	input wire embt_pkg::embt_req_t	req,
	input wire logic	reqReady,
	input wire logic	accDone,
	// Pins
	input wire logic	aleOut,
	input wire logic	rdStrobeN,
	input wire logic	wrStrobeN,
	input wire logic [7:0]	addrHigh,
	input wire logic	addrHighOe,
	input wire logic [7:0]	adOut,
	input wire logic	adOe
);
	import embt_pkg::*;
	logic [7:0]	tq, wd;
	logic [4:0]	hi, gap, lo, hc;
	logic		sh;
	wire		stb = rdStrobeN & wrStrobeN;
	wire		go = reqValid & reqReady;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Timing shadow and phase run lengths
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			{tq, wd, hi, gap, lo, hc, sh} <= {8'hff, 29'h0};
		else
		begin
			tq <= (regWrite && regAddr == EMBT_TIMING_ADDR) ? regWdata : tq;
			{wd, sh} <= go ? {req.wdata, req.shortAddr} : {wd, sh};
			hi <= aleOut ? hi + 5'h1 : 5'h0;
			gap <= aleOut ? 5'h0 : gap + 5'h1;
			lo <= stb ? 5'h0 : lo + 5'h1;
			hc <= stb ? hc + 5'h1 : 5'h0;
		end
	chk_ale_high: assert property ($fell(aleOut) |-> hi == latchWidthSelect + 5'h1)
		else $error("latch high");
	chk_low_setup: assert property ($fell(stb) |-> gap == latchWidthSelect + tq[7:6] + 5'h1)
		else $error("latch low and setup");
	chk_strobe_width: assert property ($rose(stb) |-> lo == tq[5:2] + 5'h1)
		else $error("strobe width");
	chk_addr_hold: assert property (accDone && busOperatingMode != EMBT_MODE_INT_ONLY |-> hc == tq[1:0])
		else $error("hold");
	chk_reg_read: assert property (regAddr == EMBT_TIMING_ADDR |=> regRdata == $past(tq))
		else $error("readback");
	chk_write_data: assert property (!wrStrobeN |-> adOe && adOut == wd)
		else $error("write data");
	chk_bank_byte: assert property
		(aleOut && sh && busOperatingMode == EMBT_MODE_SPLIT_B |-> addrHighOe && addrHigh == xramPageSelect)
		else $error("bank byte");
	chk_int_only: assert property (go && busOperatingMode == EMBT_MODE_INT_ONLY |-> ##1 (accDone && !aleOut))
		else $error("internal");
endmodule
bind embt_ext_mem_bus_timing embt_ext_mem_bus_timing_chk i_chk (
	.mclk             (mclk),
	.rstn             (rstn),
	.regAddr          (regAddr),
	.regWrite         (regWrite),
	.regWdata         (regWdata),
	.regRdata         (regRdata),
	.busOperatingMode (busOperatingMode),
	.latchWidthSelect (latchWidthSelect),
	.xramPageSelect   (xramPageSelect),
	.reqValid         (reqValid),
	.req              (req),
	.reqReady         (reqReady),
	.accDone          (accDone),
	.aleOut           (aleOut),
	.rdStrobeN        (rdStrobeN),
	.wrStrobeN        (wrStrobeN),
	.addrHigh         (addrHigh),
	.addrHighOe       (addrHighOe),
	.adOut            (adOut),
	.adOe             (adOe)
);

// [tb/embt_ext_mem_bus_timing_tb.sv]
// Bench for the bus timing block
`timescale 1ns/1ps
module embt_ext_mem_bus_timing_tb;
	import embt_pkg::*;
	logic		mclk = 1'h0, rstn = 1'h0, regWrite = 1'h0, reqValid = 1'h0, s;
	logic [7:0]	regAddr = 8'h00, regWdata = 8'h00, pg = 8'h00, t = 8'hff, d, hb;
	logic [1:0]	mode = 2'h0, lw = 2'h0;
	embt_req_t	req = '0;
	logic [7:0]	regRdata, readData, addrHigh, adOut, adIn;
	logic		reqReady, accDone, aleOut, rdStrobeN, wrStrobeN, addrHighOe, adOe;
	int		numErrors = 0, checked = 0, seed = 50, n;
	always #50 mclk = ~mclk;
	embt_ext_mem_bus_timing i_dut (
		.mclk             (mclk),
		.rstn             (rstn),
		.regAddr          (regAddr),
		.regWrite         (regWrite),
		.regWdata         (regWdata),
		.regRdata         (regRdata),
		.busOperatingMode (mode),
		.latchWidthSelect (lw),
		.xramPageSelect   (pg),
		.reqValid         (reqValid),
		.req              (req),
		.reqReady         (reqReady),
		.accDone          (accDone),
		.readData         (readData),
		.aleOut           (aleOut),
		.rdStrobeN        (rdStrobeN),
		.wrStrobeN        (wrStrobeN),
		.addrHigh         (addrHigh),
		.addrHighOe       (addrHighOe),
		.adOut            (adOut),
		.adOe             (adOe),
		.adIn             (adIn)
	);
	embt_xmem_model i_mem (
		.mclk       (mclk),
		.aleOut     (aleOut),
		.rdStrobeN  (rdStrobeN),
		.wrStrobeN  (wrStrobeN),
		.addrHigh   (addrHigh),
		.addrHighOe (addrHighOe),
		.adOut      (adOut),
		.adIn       (adIn)
	);
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", checked, numErrors);
		if (numErrors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic reg_io(input logic [7:0] a, input logic wr, input logic [7:0] v);
		regAddr = a;
		regWdata = v;
		regWrite = wr;
		tick;
		regWrite = 1'h0;
		tick;
	endtask
	function automatic int lat;
		return mode == EMBT_MODE_INT_ONLY ? 1 : 2 * lw + t[7:6] + t[5:2] + t[1:0] + 4;
	endfunction
	task automatic access(input logic w, input logic sa, input logic [15:0] a);
		req = '{w, sa, a, d};
		reqValid = 1'h1;
		tick;
		reqValid = 1'h0;
		check("busy ready", 8'(reqReady), 8'h00);
		for (n = 1; accDone !== 1'h1; n++)
		begin
			if (n > 60)
			begin
				numErrors++;
				report_and_stop;
			end
			tick;
		end
		check("access cycles", 8'(n), 8'(lat()));
	endtask
	initial
	begin
		repeat (10) @(posedge mclk);
		#1;
		rstn = 1'h1;
		reg_io(8'hae, 1'h1, 8'h5a);
		check("unmapped", regRdata, 8'h00);
		reg_io(EMBT_TIMING_ADDR, 1'h0, 8'h00);
		check("timing reset", regRdata, 8'hff);
		check("idle ready", 8'(reqReady), 8'h01);
		$display("test reset done");
		for (int i = 0; i < 20; i++)
		begin
			t = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
			lw = i == 0 ? 2'h0 : i == 1 ? 2'h3 : 2'($random(seed));
			mode = 2'h1 + 2'(i % 3);
			pg = 8'($random(seed));
			d = 8'($random(seed));
			s = 1'($random(seed));
			hb = !s ? 8'($random(seed)) : mode == EMBT_MODE_SPLIT_B ? pg : 8'h00;
			reg_io(EMBT_TIMING_ADDR, 1'h1, t);
			check("timing", regRdata, t);
			access(1'h1, 1'h0, {hb, 8'(i)});
			access(1'h0, s, {hb, 8'(i)});
			check("read data", readData, d);
			$display("test %0d done", i);
		end
		mode = EMBT_MODE_INT_ONLY;
		access(1'h0, 1'h0, 16'h0000);
		check("internal read", readData, 8'h00);
		$display("test internal done");
		tick;
		report_and_stop;
	end
endmodule

// [tb/embt_xmem_model.sv]
// External memory on the shared bus
`timescale 1ns/1ps
module embt_xmem_model (
	// Clock
	input wire logic	mclk,
	// Pins
	input wire logic	aleOut,
	input wire logic	rdStrobeN,
	input wire logic	wrStrobeN,
	input wire logic [7:0]	addrHigh,
	input wire logic	addrHighOe,
	input wire logic [7:0]	adOut,
	output logic [7:0]	adIn
);
	logic [7:0]	mem [0:65535];
	logic [15:0]	a;
	logic [7:0]	q;
	always @(posedge mclk)
	begin
		a <= aleOut ? {addrHighOe ? addrHigh : 8'h00, adOut} : a;
		if (!wrStrobeN)
			mem[a] <= adOut;
		q <= rdStrobeN ? q : mem[a];
	end
	// Released lines show the inverse of the last value
	assign adIn = rdStrobeN ? ~q : mem[a];
endmodule
